// [core/pin_mux_pkg.sv]
// Constants, types and carriers shared by the multifunction pin mux.
// Assumes a single core clock; pad levels arrive as plain synchronous inputs.
package pin_mux_pkg;

    localparam int NPAD = 11;
    localparam int FN_W = 4;

    // Function codes that a pad may carry
    typedef enum logic [FN_W-1:0] {
        FN_GPIO = 4'h0,
        FN_PT_I2C1 = 4'h1,
        FN_PT_UART1 = 4'h2,
        FN_PT_I2C2 = 4'h3,
        FN_PT_UART2 = 4'h4,
        FN_FSYNC_OUT = 4'h5,
        FN_FSYNC_IN = 4'h6,
        FN_VSYNC = 4'h7,
        FN_VALID = 4'h8,
        FN_SPI = 4'h9,
        FN_UART_MODE = 4'hA,
        FN_LOCK = 4'hB,
        FN_FAULT = 4'hC,
        FN_SENSE = 4'hD
    } func_t;

    // Pads on which each function exists, one bit per pad
    localparam logic [NPAD-1:0] ALLOW_GPIO = 11'h7FF;
    localparam logic [NPAD-1:0] ALLOW_PT = 11'h063;
    localparam logic [NPAD-1:0] ALLOW_FSYNC_OUT = 11'h001;
    localparam logic [NPAD-1:0] ALLOW_FSYNC_IN = 11'h042;
    localparam logic [NPAD-1:0] ALLOW_MONITOR = 11'h009;
    localparam logic [NPAD-1:0] ALLOW_SPI = 11'h0FD;
    localparam logic [NPAD-1:0] ALLOW_UART_MODE = 11'h001;
    localparam logic [NPAD-1:0] ALLOW_LOCK = 11'h002;
    localparam logic [NPAD-1:0] ALLOW_FAULT = 11'h010;
    localparam logic [NPAD-1:0] ALLOW_SENSE = 11'h780;

    // Pad roles inside the mux
    localparam logic [NPAD-1:0] PADS_STRAP = 11'h00C;
    localparam logic [NPAD-1:0] PADS_OPEN_DRAIN_GP = 11'h060;
    localparam logic [NPAD-1:0] PADS_INPUT_ONLY = 11'h780;
    localparam logic [NPAD-1:0] PADS_PT_DATA = 11'h021;
    localparam int PAD_STRAP_ZERO = 2;
    localparam int PAD_STRAP_ONE = 3;
    localparam int PAD_SENSE_BASE = 7;

    // Power-up functions, four bits per pad, pad 10 leftmost
    localparam logic [NPAD*FN_W-1:0] FUNC_RESET = 44'h0000_22C0_0B0;
    // Power-up pulls
    localparam logic [NPAD-1:0] PULLUP_RESET = 11'h072;
    localparam logic [NPAD-1:0] PULLDOWN_RESET = 11'h781;

    // Strap capture waits for the synchroniser to fill
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int UART1_BPS = 1_000_000;
    localparam int UART1_DIV = CLK_HZ / UART1_BPS;
    localparam int DIV_W = 8;

    // Drive of every pad
    typedef struct packed {
        logic [NPAD-1:0] o;
        logic [NPAD-1:0] oe;
        logic [NPAD-1:0] pu;
        logic [NPAD-1:0] pd;
    } pad_drv_t;

    // SPI engine towards the pads
    typedef struct packed {
        logic master;
        logic sclk_out;
        logic mosi_out;
        logic miso_out;
        logic ss1;
        logic ss2;
        logic data_waiting;
    } spi_core_t;

    // Pad levels handed to the internal functions
    typedef struct packed {
        logic spi_sclk;
        logic spi_mosi;
        logic spi_miso;
        logic spi_dir_select;
        logic frame_sync_input;
        logic [1:0][1:0] pt_in;
        logic [3:0] fault_sense;
        logic [NPAD-1:0] link_gpio_in;
        logic [NPAD-1:0] reg_gpio_in;
        logic uart_bypass;
        logic [1:0] strap;
        logic strap_valid;
        logic ctrl_uart_sel;
        logic uart1_tick;
    } core_out_t;

endpackage

// [core/multifunction_pin_mux.sv]
// Multifunction pad multiplexer: maps eleven shared pads onto internal functions.
// Assumes pad levels are synchronous inputs and pad buffers act on o/oe/pu/pd.
// Behaviour
// - mode pin low base, high bypass, overridable
// - external master drives read/write select
// - slave drives data-waiting high when data held
// - fault pad pulled low on error conditions
// - fault pad released during power-down
// - straps sampled once, then ignored
// - pad zero powers up pulled-down input
// - strap-shared outputs power up high impedance
// - pads five, six open-drain released, receiving
// - SPI clock output master, pulled-down input slave
// - MOSI drives in master, receives in slave
// - MISO receives in master, drives in slave
// - master drives two slave selects on strap pads
// - first UART channel defaults to 1 Mbps
// - legacy mode GPIO reached only through registers
// - pads power up in default functions
// - lock pad is open-drain lock indication
// - per-stream sync and valid monitor outputs
// - pads seven to ten sense or input
// - frame sync out on pad zero, in elsewhere
// - control channel I2C or UART from strap
`timescale 1ns/1ns

module multifunction_pin_mux
    import pin_mux_pkg::*;
#(
    parameter int UART_DIV = UART1_DIV
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [NPAD-1:0] PAD_IN_I,
    input wire logic [NPAD*FN_W-1:0] FUNC_SEL_I,
    input wire logic FUNC_LOAD_I,
    input wire logic LEGACY_MODE_I,
    input wire logic [NPAD-1:0] GPIO_OE_I,
    input wire logic [NPAD-1:0] REG_GPIO_OUT_I,
    input wire logic [NPAD-1:0] LINK_GPIO_OUT_I,
    input wire spi_core_t SPI_CORE_I,
    input wire logic [1:0][1:0] PT_PULL_LOW_I,
    input wire logic FRAME_SYNC_OUTPUT_I,
    input wire logic [1:0] VSYNC_I,
    input wire logic [1:0] VALID_I,
    input wire logic LINK_LOCK_I,
    input wire logic DATA_ERROR_I,
    input wire logic LINE_FAULT_I,
    input wire logic IRQ_I,
    input wire logic IRQ_EN_I,
    input wire logic POWER_DOWN_N_I,
    input wire logic UART_MODE_OVR_EN_I,
    input wire logic UART_MODE_OVR_I,
    output pad_drv_t PAD_DRV_O,
    output core_out_t CORE_O,
    output logic [NPAD*FN_W-1:0] FUNC_ACTIVE_O
);

    // Whole state of the mux
    typedef struct packed {
        logic [NPAD-1:0] sync1;
        logic [NPAD-1:0] sync2;
        logic [NPAD*FN_W-1:0] func;
        pad_drv_t drv;
        core_out_t out;
        logic [1:0] strap_cnt;
        logic [DIV_W-1:0] div_cnt;
    } state_t;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(UART_DIV - 1);

    state_t st_r;
    state_t st_nxt;

    // Pad on which a function may stand
    function automatic logic fn_allowed(input func_t fn, input int p);
        logic [NPAD-1:0] m;
        m = '0;
        unique case (fn)
            FN_GPIO: m = ALLOW_GPIO;
            FN_PT_I2C1, FN_PT_UART1, FN_PT_I2C2, FN_PT_UART2: m = ALLOW_PT;
            FN_FSYNC_OUT: m = ALLOW_FSYNC_OUT;
            FN_FSYNC_IN: m = ALLOW_FSYNC_IN;
            FN_VSYNC, FN_VALID: m = ALLOW_MONITOR;
            FN_SPI: m = ALLOW_SPI;
            FN_UART_MODE: m = ALLOW_UART_MODE;
            FN_LOCK: m = ALLOW_LOCK;
            FN_FAULT: m = ALLOW_FAULT;
            FN_SENSE: m = ALLOW_SENSE;
            default: m = '0;
        endcase
        return m[p];
    endfunction

    // Next state: synchronise, capture straps, select and drive pads
    always_comb begin
        func_t fn;
        logic fault_on;
        logic gp_val;
        logic [1:0] ch;
        int strm;
        fn = FN_GPIO;
        fault_on = 1'b0;
        gp_val = 1'b0;
        ch = '0;
        strm = 0;
        st_nxt = st_r;
        st_nxt.sync1 = PAD_IN_I;
        st_nxt.sync2 = st_r.sync1;
        // Drivers and pulls released unless a function below claims them
        st_nxt.drv = '0;
        st_nxt.out.spi_sclk = 1'b0;
        st_nxt.out.spi_mosi = 1'b0;
        st_nxt.out.spi_miso = 1'b0;
        st_nxt.out.spi_dir_select = 1'b0;
        st_nxt.out.frame_sync_input = 1'b0;
        st_nxt.out.pt_in = '1;
        st_nxt.out.fault_sense = '0;
        st_nxt.out.link_gpio_in = '0;
        st_nxt.out.reg_gpio_in = '0;

        // Straps: one capture after the synchroniser fills, never again
        if (!st_r.out.strap_valid) begin
            if (st_r.strap_cnt == STRAP_WAIT) begin
                st_nxt.out.strap = {st_r.sync2[PAD_STRAP_ONE], st_r.sync2[PAD_STRAP_ZERO]};
                st_nxt.out.strap_valid = 1'b1;
                st_nxt.out.ctrl_uart_sel = st_r.sync2[PAD_STRAP_ZERO];
            end else begin
                st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            end
        end

        // Function table reload from configuration
        if (FUNC_LOAD_I) begin
            st_nxt.func = FUNC_SEL_I;
        end

        // Bit-rate enable for the first UART channel
        st_nxt.out.uart1_tick = 1'b0;
        if (st_r.div_cnt == DIV_LAST) begin
            st_nxt.div_cnt = '0;
            st_nxt.out.uart1_tick = 1'b1;
        end else begin
            st_nxt.div_cnt = st_r.div_cnt + DIV_W'(1);
        end

        // Fault causes: data error, line fault or an enabled interrupt
        fault_on = DATA_ERROR_I | LINE_FAULT_I | (IRQ_I & IRQ_EN_I);

        // Per pad: only the selected function reaches the drivers
        for (int p = 0; p < NPAD; p++) begin
            fn = func_t'(st_r.func[p*FN_W +: FN_W]);
            if (!fn_allowed(fn, p)) begin
                fn = FN_GPIO;
            end
            // Strap pads stay released until their level is captured
            if (PADS_STRAP[p] && !st_r.out.strap_valid) begin
                fn = FN_GPIO;
            end
            // Lane of a pass-through pad and stream of a monitor pad
            ch = (PADS_PT_DATA[p]) ? 2'h0 : 2'h1;
            strm = (p == 0) ? 1 : 0;
            unique case (fn)
                // General purpose: register or link data, style by pad role
                FN_GPIO: begin
                    gp_val = LEGACY_MODE_I ? REG_GPIO_OUT_I[p] : LINK_GPIO_OUT_I[p];
                    if (LEGACY_MODE_I) begin
                        st_nxt.out.reg_gpio_in[p] = st_r.sync2[p];
                    end else begin
                        st_nxt.out.link_gpio_in[p] = st_r.sync2[p];
                        st_nxt.out.reg_gpio_in[p] = st_r.sync2[p];
                    end
                    // Input only, open drain, strap-shared or push-pull pad
                    if (PADS_INPUT_ONLY[p]) begin
                        st_nxt.drv.pd[p] = 1'b1;
                    end else if (PADS_OPEN_DRAIN_GP[p]) begin
                        st_nxt.drv.pu[p] = 1'b1;
                        st_nxt.drv.oe[p] = GPIO_OE_I[p] & ~gp_val;
                    end else if (PADS_STRAP[p]) begin
                        st_nxt.drv.oe[p] = GPIO_OE_I[p] & st_r.out.strap_valid;
                        st_nxt.drv.o[p] = gp_val;
                    end else begin
                        st_nxt.drv.oe[p] = GPIO_OE_I[p];
                        st_nxt.drv.o[p] = gp_val;
                        st_nxt.drv.pd[p] = (p == 0) & ~GPIO_OE_I[p];
                    end
                end
                // Pass-through lines: open drain with pull-up
                FN_PT_I2C1, FN_PT_UART1, FN_PT_I2C2, FN_PT_UART2: begin
                    // Channel from the code; lane 0 on pads 0 and 5, lane 1 on pads 1 and 6
                    if ((fn == FN_PT_I2C1) || (fn == FN_PT_UART1)) begin
                        st_nxt.out.pt_in[0][ch[0]] = st_r.sync2[p];
                        st_nxt.drv.oe[p] = PT_PULL_LOW_I[0][ch[0]];
                    end else begin
                        st_nxt.out.pt_in[1][ch[0]] = st_r.sync2[p];
                        st_nxt.drv.oe[p] = PT_PULL_LOW_I[1][ch[0]];
                    end
                    st_nxt.drv.pu[p] = 1'b1;
                end
                // Frame sync push-pull output
                FN_FSYNC_OUT: begin
                    st_nxt.drv.oe[p] = 1'b1;
                    st_nxt.drv.o[p] = FRAME_SYNC_OUTPUT_I;
                end
                // Frame sync input held low by its pull-down
                FN_FSYNC_IN: begin
                    st_nxt.drv.pd[p] = 1'b1;
                    st_nxt.out.frame_sync_input = st_r.sync2[p];
                end
                // Vertical sync monitor of one stream
                FN_VSYNC: begin
                    st_nxt.drv.oe[p] = 1'b1;
                    st_nxt.drv.o[p] = VSYNC_I[strm];
                end
                // Data-valid monitor of one stream
                FN_VALID: begin
                    st_nxt.drv.oe[p] = 1'b1;
                    st_nxt.drv.o[p] = VALID_I[strm];
                end
                // SPI signals; direction of pads 0, 3, 5 and 6 follows the role
                FN_SPI: begin
                    // Pad zero: serial clock
                    if (p == 0) begin
                        st_nxt.drv.oe[p] = SPI_CORE_I.master;
                        st_nxt.drv.o[p] = SPI_CORE_I.sclk_out;
                        st_nxt.drv.pd[p] = ~SPI_CORE_I.master;
                        st_nxt.out.spi_sclk = SPI_CORE_I.master ? SPI_CORE_I.sclk_out : st_r.sync2[p];
                    end else if (p == 5) begin
                        // Master-out data line
                        st_nxt.drv.oe[p] = SPI_CORE_I.master;
                        st_nxt.drv.o[p] = SPI_CORE_I.mosi_out;
                        st_nxt.drv.pd[p] = ~SPI_CORE_I.master;
                        st_nxt.out.spi_mosi = st_r.sync2[p];
                    end else if (p == 6) begin
                        // Master-in data line
                        st_nxt.drv.oe[p] = ~SPI_CORE_I.master;
                        st_nxt.drv.o[p] = SPI_CORE_I.miso_out;
                        st_nxt.drv.pd[p] = SPI_CORE_I.master;
                        st_nxt.out.spi_miso = st_r.sync2[p];
                    end else if (p == PAD_STRAP_ZERO) begin
                        // First select as master, data waiting as slave
                        st_nxt.drv.oe[p] = 1'b1;
                        st_nxt.drv.o[p] = SPI_CORE_I.master ? SPI_CORE_I.ss1 : SPI_CORE_I.data_waiting;
                    end else if (p == PAD_STRAP_ONE) begin
                        // Second select, driven only as master
                        st_nxt.drv.oe[p] = SPI_CORE_I.master;
                        st_nxt.drv.o[p] = SPI_CORE_I.ss2;
                    end else begin
                        // Pads 4 and 7: read/write select from the external master
                        st_nxt.drv.pd[p] = 1'b1;
                        if (!SPI_CORE_I.master) begin
                            st_nxt.out.spi_dir_select = st_r.sync2[p];
                        end
                    end
                end
                // Mode select pin, overridable from configuration
                FN_UART_MODE: begin
                    st_nxt.drv.pd[p] = 1'b1;
                    st_nxt.out.uart_bypass = UART_MODE_OVR_EN_I ? UART_MODE_OVR_I : st_r.sync2[p];
                end
                // Lock indication: pulled low while unlocked
                FN_LOCK: begin
                    st_nxt.drv.pu[p] = 1'b1;
                    st_nxt.drv.oe[p] = ~LINK_LOCK_I;
                end
                // Fault flag: pulled low on any cause, released in power-down
                FN_FAULT: begin
                    st_nxt.drv.pu[p] = 1'b1;
                    st_nxt.drv.oe[p] = fault_on & POWER_DOWN_N_I;
                end
                // Line-fault sense inputs, pads seven to ten
                FN_SENSE: begin
                    st_nxt.out.fault_sense[2'(p - PAD_SENSE_BASE)] = st_r.sync2[p];
                end
                // Not reached once illegal codes fall back to general purpose
                default: begin
                    st_nxt.drv.oe[p] = 1'b0;
                end
            endcase
        end
    end

    // State register with power-up defaults
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            st_r <= '0;
            st_r.func <= FUNC_RESET;
            st_r.drv.pu <= PULLUP_RESET;
            st_r.drv.pd <= PULLDOWN_RESET;
            st_r.out.pt_in <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign PAD_DRV_O = st_r.drv;
    assign CORE_O = st_r.out;
    assign FUNC_ACTIVE_O = st_r.func;

endmodule // multifunction_pin_mux

// [dv/multifunction_pin_mux_checker.sv]
// Concurrent checks on the pin mux top-level ports.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pin_mux_checker
    import pin_mux_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic LINK_LOCK_I,
    input wire logic DATA_ERROR_I,
    input wire logic LINE_FAULT_I,
    input wire logic IRQ_I,
    input wire logic IRQ_EN_I,
    input wire logic POWER_DOWN_N_I,
    input wire spi_core_t SPI_CORE_I,
    input wire pad_drv_t PAD_DRV_O,
    input wire core_out_t CORE_O,
    input wire logic [NPAD*FN_W-1:0] FUNC_ACTIVE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    // Fault causes and whether pad 4 carries the fault flag
    wire logic flt = DATA_ERROR_I | LINE_FAULT_I | (IRQ_I & IRQ_EN_I);
    wire logic is_flt = FUNC_ACTIVE_O[19:16] == FN_FAULT;
    wire logic is_spi = FUNC_ACTIVE_O[27:20] == {FN_SPI, FN_SPI};

    chk_fault_pull: assert property (is_flt && flt && POWER_DOWN_N_I |=> PAD_DRV_O.oe[4] && !PAD_DRV_O.o[4])
        else $error("fault pad not pulled low");
    chk_fault_idle: assert property (is_flt && !(flt && POWER_DOWN_N_I) |=> !PAD_DRV_O.oe[4])
        else $error("fault pad not released");
    chk_strap_keep: assert property (CORE_O.strap_valid && $past(CORE_O.strap_valid) |-> $stable(CORE_O.strap))
        else $error("strap value changed after capture");
    chk_strap_time: assert property ($fell(RESET_I) |-> ##[1:5] CORE_O.strap_valid)
        else $error("strap not captured in time");
    chk_boot_state: assert property ($fell(RESET_I) |-> {PAD_DRV_O.oe, PAD_DRV_O.pd, PAD_DRV_O.pu} == 33'h03C_0872)
        else $error("pad drive wrong after reset");
    chk_strap_hiz: assert property (!CORE_O.strap_valid |-> PAD_DRV_O.oe[3:2] == 2'h0)
        else $error("strap pad driven before capture");
    chk_sclk_role: assert property (FUNC_ACTIVE_O[3:0] == FN_SPI |=> PAD_DRV_O.oe[0] == $past(SPI_CORE_I.master))
        else $error("clock pad direction wrong for role");
    chk_data_dir: assert property (is_spi |=> PAD_DRV_O.oe[6:5] == {!$past(SPI_CORE_I.master), $past(SPI_CORE_I.master)})
        else $error("data pad direction wrong for role");
    chk_lock_drain: assert property (FUNC_ACTIVE_O[7:4] == FN_LOCK |=> PAD_DRV_O.oe[1] != $past(LINK_LOCK_I) && !PAD_DRV_O.o[1])
        else $error("lock pad not open-drain lock state");

    cov_fault: cover property (is_flt && DATA_ERROR_I && POWER_DOWN_N_I);
    cov_slave: cover property (is_spi && !SPI_CORE_I.master);
    cov_strap: cover property ($rose(CORE_O.strap_valid));
endmodule // pin_mux_checker

bind multifunction_pin_mux pin_mux_checker pin_mux_checker_inst (.CLK_I, .RESET_I, .LINK_LOCK_I, .DATA_ERROR_I,
    .LINE_FAULT_I, .IRQ_I, .IRQ_EN_I, .POWER_DOWN_N_I, .SPI_CORE_I, .PAD_DRV_O, .CORE_O, .FUNC_ACTIVE_O);

// [dv/pad_partner.sv]
// Far-side pad model: external peripherals, pulls and floating pads.
// Assumes the bench sets what the outside world drives on each pad.
`timescale 1ns/1ns
module pad_partner
    import pin_mux_pkg::*;
(
    input wire logic clk_i,
    input wire pad_drv_t drv_i,
    input wire logic [NPAD-1:0] ext_oe_i,
    input wire logic [NPAD-1:0] ext_o_i,
    output logic [NPAD-1:0] pad_o
);
    logic flip_r = 1'b0;
    // Unpulled undriven pads wander every cycle
    always @(posedge clk_i) begin
        flip_r <= !flip_r;
    end
    // Wire level: low wins, then drivers, then pulls
    always_comb begin
        for (int p = 0; p < NPAD; p++) begin
            if (drv_i.oe[p] && ext_oe_i[p]) begin
                pad_o[p] = drv_i.o[p] & ext_o_i[p];
            end else if (drv_i.oe[p]) begin
                pad_o[p] = drv_i.o[p];
            end else if (ext_oe_i[p]) begin
                pad_o[p] = ext_o_i[p];
            end else begin
                pad_o[p] = drv_i.pu[p] | (!drv_i.pd[p] & flip_r);
            end
        end
    end
endmodule // pad_partner

// [dv/multifunction_pin_mux_tb.sv]
// Self-checking bench for the multifunction pin mux.
// Assumes the pad partner model resolves every pad level.
`timescale 1ns/1ns
module multifunction_pin_mux_tb;
    import pin_mux_pkg::*;
    logic CLK_I = 1'b0, RESET_I = 1'b1, FUNC_LOAD_I = 1'b0, LEGACY_MODE_I = 1'b0, FRAME_SYNC_OUTPUT_I = 1'b0;
    logic LINK_LOCK_I = 1'b0, DATA_ERROR_I = 1'b0, LINE_FAULT_I = 1'b0, IRQ_I = 1'b0, IRQ_EN_I = 1'b0;
    logic POWER_DOWN_N_I = 1'b1, UART_MODE_OVR_EN_I = 1'b0, UART_MODE_OVR_I = 1'b0;
    logic [NPAD-1:0] PAD_IN_I, GPIO_OE_I = 11'h001, REG_GPIO_OUT_I = 11'h001, LINK_GPIO_OUT_I = 11'h000;
    logic [NPAD-1:0] ext_oe = 11'h00C, ext_o = 11'h004;
    logic [43:0] FUNC_SEL_I = 44'h0, FUNC_ACTIVE_O, dflt;
    logic [1:0][1:0] PT_PULL_LOW_I = 4'h0;
    logic [1:0] VSYNC_I = 2'h0, VALID_I = 2'h0;
    spi_core_t SPI_CORE_I = 7'h00;
    pad_drv_t PAD_DRV_O;
    core_out_t CORE_O;
    int fails = 0, n_compared = 0;

    initial forever #50 CLK_I = !CLK_I;
    multifunction_pin_mux multifunction_pin_mux_inst (.CLK_I, .RESET_I, .PAD_IN_I, .FUNC_SEL_I, .FUNC_LOAD_I,
        .LEGACY_MODE_I, .GPIO_OE_I, .REG_GPIO_OUT_I, .LINK_GPIO_OUT_I, .SPI_CORE_I, .PT_PULL_LOW_I,
        .FRAME_SYNC_OUTPUT_I, .VSYNC_I, .VALID_I, .LINK_LOCK_I, .DATA_ERROR_I, .LINE_FAULT_I, .IRQ_I,
        .IRQ_EN_I, .POWER_DOWN_N_I, .UART_MODE_OVR_EN_I, .UART_MODE_OVR_I, .PAD_DRV_O, .CORE_O, .FUNC_ACTIVE_O);
    pad_partner pad_partner_inst (.clk_i(CLK_I), .drv_i(PAD_DRV_O), .ext_oe_i(ext_oe), .ext_o_i(ext_o), .pad_o(PAD_IN_I));

    // Helpers: wait, compare, set one pad code, load table
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_I);
    endtask
    task automatic chk(input string what, input logic [43:0] exp, input logic [43:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [43:0] put(input logic [43:0] b, input int p, input func_t c);
        b[4*p+:4] = c;
        return b;
    endfunction
    task automatic load(input logic [43:0] f);
        FUNC_SEL_I = f;
        FUNC_LOAD_I = 1'b1;
        cyc(1);
        FUNC_LOAD_I = 1'b0;
        cyc(2);
    endtask

    // Power-up defaults and strap capture
    task automatic t_boot;
        int i;
        dflt = put(put(put(put(44'h0, 1, FN_LOCK), 4, FN_FAULT), 5, FN_PT_UART1), 6, FN_PT_UART1);
        chk("func table", dflt, FUNC_ACTIVE_O);
        chk("pulls", 22'h3C0872, {PAD_DRV_O.pd, PAD_DRV_O.pu});
        for (i = 0; i < 8 && CORE_O.strap_valid !== 1'b1; i++) cyc(1);
        chk("strap", 44'h1, CORE_O.strap);
        chk("ctrl uart", 44'h1, CORE_O.ctrl_uart_sel);
        ext_o = 11'h008;
        cyc(5);
        chk("strap kept", 44'h1, CORE_O.strap);
        ext_oe = 11'h000;
    endtask

    // Fault flag causes and power-down release
    task automatic t_fault;
        logic [5:0] tab [6] = '{6'h31, 6'h32, 6'h3C, 6'h14, 6'h01, 6'h18};
        foreach (tab[k]) begin
            {POWER_DOWN_N_I, IRQ_EN_I, IRQ_I, LINE_FAULT_I, DATA_ERROR_I} = tab[k][4:0];
            cyc(1);
            chk("fault oe", tab[k][5], PAD_DRV_O.oe[4]);
        end
        {POWER_DOWN_N_I, IRQ_EN_I, IRQ_I, LINE_FAULT_I, DATA_ERROR_I} = 5'h10;
    endtask

    // SPI pads in master then slave role
    task automatic t_spi;
        logic [43:0] f = dflt;
        int pl [6] = '{0, 2, 3, 5, 6, 7};
        foreach (pl[i]) f = put(f, pl[i], FN_SPI);
        SPI_CORE_I = 7'h73;
        load(f);
        chk("master oe", 11'h02D, PAD_DRV_O.oe & 11'h06D);
        chk("master out", 11'h029, PAD_DRV_O.o & 11'h02D);
        SPI_CORE_I = 7'h09;
        ext_oe = 11'h0A1;
        ext_o = 11'h0A1;
        cyc(2);
        chk("dir early", 44'h0, CORE_O.spi_dir_select);
        cyc(1);
        chk("slave oe", 11'h044, PAD_DRV_O.oe & 11'h065);
        chk("slave out", 11'h044, PAD_DRV_O.o & 11'h044);
        chk("slave in", 44'hF, {PAD_DRV_O.pd[0], CORE_O.spi_dir_select, CORE_O.spi_mosi, CORE_O.spi_sclk});
        ext_oe = 11'h000;
    endtask

    // Mode pin level and override
    task automatic t_mode;
        load(put(dflt, 0, FN_UART_MODE));
        ext_oe = 11'h001;
        for (int l = 0; l < 2; l++) begin
            ext_o = 11'(l);
            cyc(4);
            chk("bypass", 44'(l), CORE_O.uart_bypass);
        end
        UART_MODE_OVR_EN_I = 1'b1;
        cyc(4);
        chk("bypass ovr", 44'h0, CORE_O.uart_bypass);
        UART_MODE_OVR_EN_I = 1'b0;
        ext_oe = 11'h000;
    endtask

    // Lock, bit tick, legacy GPIO, sync monitors
    task automatic t_misc;
        int n = 0;
        load(dflt);
        chk("unlocked", 44'h1, PAD_DRV_O.oe[1]);
        LINK_LOCK_I = 1'b1;
        LINK_GPIO_OUT_I = 11'h000;
        repeat (100) begin
            cyc(1);
            n += int'(CORE_O.uart1_tick === 1'b1);
        end
        chk("locked", 44'h0, PAD_DRV_O.oe[1]);
        chk("ticks", 44'd10, 44'(n));
        for (int g = 0; g < 2; g++) begin
            LEGACY_MODE_I = 1'(g);
            cyc(1);
            chk("legacy gpio", 44'(g), PAD_DRV_O.o[0]);
        end
        load(put(put(dflt, 3, FN_VSYNC), 0, FN_VALID));
        for (int v = 0; v < 2; v++) begin
            VSYNC_I = 2'(v);
            VALID_I = 2'(2 * v);
            cyc(1);
            chk("monitors", {2'h3, 1'(v), 1'(v)},
                {PAD_DRV_O.oe[3], PAD_DRV_O.oe[0], PAD_DRV_O.o[3], PAD_DRV_O.o[0]});
        end
    endtask

    // Frame sync, refused code, sense inputs, pass-through pull, GPIO readback
    task automatic t_path;
        logic [43:0] f = put(put(put(dflt, 0, FN_FSYNC_OUT), 2, FN_FSYNC_OUT), 6, FN_FSYNC_IN);
        for (int p = 7; p < NPAD; p++) f = put(f, p, FN_SENSE);
        FRAME_SYNC_OUTPUT_I = 1'b1;
        PT_PULL_LOW_I = 4'h1;
        load(f);
        ext_oe = 11'h7C0;
        ext_o = 11'h540;
        cyc(4);
        chk("fsync", 44'h7,
            {PAD_DRV_O.oe[2], PAD_DRV_O.oe[0], PAD_DRV_O.o[0], CORE_O.frame_sync_input});
        chk("sense", 44'hA, CORE_O.fault_sense);
        chk("pt pull", 44'h2E, {PAD_DRV_O.oe[5], PAD_DRV_O.o[5], CORE_O.pt_in});
        PT_PULL_LOW_I = 4'h0;
        load(dflt);
        for (int g = 0; g < 2; g++) begin
            LEGACY_MODE_I = 1'(g);
            cyc(4);
            chk("gpio in", g ? 44'h501 : 44'h280500,
                {CORE_O.link_gpio_in & 11'h781, CORE_O.reg_gpio_in & 11'h781});
        end
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(2);
        RESET_I = 1'b0;
        t_boot();
        t_fault();
        t_spi();
        t_mode();
        t_misc();
        t_path();
        summarize();
    end
    initial begin
        cyc(5000);
        fails++;
        $display("mismatch run expected done seen hang");
        summarize();
    end
endmodule // multifunction_pin_mux_tb
